// File: include/cmp_ctrl_cfg.svh
// Purpose: offsets, field positions and reset values of the comparator control block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   8-bit registers sit in the low byte, upper bits read zero
`ifndef CMP_CTRL_CFG_SVH
`define CMP_CTRL_CFG_SVH

`define CMP_OFS_CTRL0_C1  8'h00
`define CMP_OFS_CTRL1_C1  8'h04
`define CMP_OFS_CTRL0_C2  8'h08
`define CMP_OFS_CTRL1_C2  8'h0C
`define CMP_OFS_MIRROR    8'h10
`define CMP_OFS_FLAGS     8'h14
`define CMP_OFS_PINCFG    8'h18
`define CMP_OFS_PORTRD    8'h1C

`define CMP_BIT_ENABLE    7
`define CMP_BIT_RESULT    6
`define CMP_BIT_ROUTE     5
`define CMP_BIT_INVERT    4
`define CMP_BIT_SPEED     2
`define CMP_BIT_HYST      1
`define CMP_BIT_SYNC      0
`define CMP_BIT_RISE      7
`define CMP_BIT_FALL      6
`define CMP_POS_HI        5
`define CMP_POS_LO        4
`define CMP_NEG_HI        1
`define CMP_NEG_LO        0

`define CMP_CTRL0_RST     8'h04
`define CMP_CTRL1_RST     8'h00
`define CMP_PINCFG_RST    8'h00
`define CMP_CTRL0_WMASK   8'hB7
`define CMP_CTRL1_WMASK   8'hF3

`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2

`endif

// File: include/cmp_ctrl_pkg.sv
// Purpose: shared types of the comparator control block
// Assumes: nothing beyond the cfg header
// Notes:   positive-input codes mirror the two-bit select field
package cmp_ctrl_pkg;
    typedef enum logic [1:0] {
        POS_OWN_PIN   = 2'b00,
        POS_DAC_REF   = 2'b01,
        POS_FIXED_REF = 2'b10,
        POS_ALT       = 2'b11
    } pos_sel_type;

    typedef enum logic [1:0] {
        NEG_PIN_ZERO  = 2'b00,
        NEG_PIN_ONE   = 2'b01,
        NEG_PIN_TWO   = 2'b10,
        NEG_PIN_THREE = 2'b11
    } neg_sel_type;
endpackage : cmp_ctrl_pkg

// File: core/cmp_channel.sv
// Purpose: one comparator's result path: synchroniser, polarity, edge pulses, pin sync
// Assumes: raw_result is asynchronous; timer_clk_in is sampled on ref_clk
// Notes:   analog selects are not handled here; cmp_ctrl passes them straight through as two-bit codes
`timescale 1ns/1ps
module cmp_channel (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        raw_result,
    input  wire logic        enable,
    input  wire logic        invert,
    input  wire logic        sync_sel,
    input  wire logic        rise_en,
    input  wire logic        fall_en,
    input  wire logic        timer_fall,
    output logic             result_q,
    output logic             ext_result,
    output logic             edge_pulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic latched_q;
    logic result_d;

    // raw result crosses into the core domain before any use
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= raw_result;
            sync_q <= meta_q;
        end
    end

    // a disabled comparator reads low before polarity, so toggling enable
    // or polarity can still produce an edge
    assign result_d = (sync_q & enable) ^ invert;

    // internal result latched once per core cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            result_q <= 1'b0;
            prev_q   <= 1'b0;
        end else begin
            result_q <= result_d;
            prev_q   <= result_q;
        end
    end

    // one-cycle pulse per qualifying edge
    assign edge_pulse = (rise_en & result_q & ~prev_q) | (fall_en & ~result_q & prev_q);

    // falling edge of prescaled timer clock latches the external copy
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            latched_q <= 1'b0;
        end else if (timer_fall) begin
            latched_q <= result_q;
        end
    end

    assign ext_result = sync_sel ? latched_q : result_d;
endmodule : cmp_channel

// File: core/cmp_ctrl.sv
// Purpose: dual comparator control and status with an AXI4-Lite register slave
// Assumes: ref_clk 250 MHz; sys_rst synchronous active high; timer clock synchronous
// Notes:   analog controls leave as plain outputs; interrupt flags are per-comparator bits
`timescale 1ns/1ps
`include "cmp_ctrl_cfg.svh"

module cmp_ctrl
    import cmp_ctrl_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [1:0]              raw_result,
    input  wire logic                    timer_clk_in,
    input  wire logic [1:0]              pin_direction_bit,
    input  wire logic [7:0]              port_pins_in,
    output logic [1:0]                   cmp_pin_out,
    output logic [1:0]                   cmp_pin_oe,
    output logic [1:0]                   timer_gate_result,
    output logic [1:0]                   cmp_irq_flag,
    output logic [1:0]                   analog_enable,
    output logic [1:0]                   analog_speed_fast,
    output logic [1:0]                   analog_hyst_en,
    output logic [1:0]                   analog_inputs_on,
    output pos_sel_type                  cmp_pos_sel [2],
    output neg_sel_type                  cmp_neg_sel [2]
);
    import cmp_ctrl_pkg::*;

    //--------------------------------------------------------------
    // registers
    //--------------------------------------------------------------
    logic [7:0] ctrl0_q [2];
    logic [7:0] ctrl1_q [2];
    logic [7:0] analog_cfg_q;
    logic [1:0] flag_q;
    logic [1:0] result_q;
    logic [1:0] edge_pulse;
    logic [1:0] ext_result;
    logic       timer_prev_q;
    logic       timer_fall;

    logic       aw_full_q;
    logic       w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic       wr_fire;
    logic       wr_ok;

    //--------------------------------------------------------------
    // timer clock edge detect
    //--------------------------------------------------------------
    // timer clock is already synchronous to ref_clk, so one flop finds its fall
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_prev_q <= 1'b0;
        end else begin
            timer_prev_q <= timer_clk_in;
        end
    end
    assign timer_fall = timer_prev_q & ~timer_clk_in;

    //--------------------------------------------------------------
    // per-comparator logic
    //--------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_cmp
        cmp_channel u_chan (
            .ref_clk    (ref_clk),
            .sys_rst    (sys_rst),
            .raw_result (raw_result[i]),
            .enable     (ctrl0_q[i][`CMP_BIT_ENABLE]),
            .invert     (ctrl0_q[i][`CMP_BIT_INVERT]),
            .sync_sel   (ctrl0_q[i][`CMP_BIT_SYNC]),
            .rise_en    (ctrl1_q[i][`CMP_BIT_RISE]),
            .fall_en    (ctrl1_q[i][`CMP_BIT_FALL]),
            .timer_fall (timer_fall),
            .result_q   (result_q[i]),
            .ext_result (ext_result[i]),
            .edge_pulse (edge_pulse[i])
        );

        assign timer_gate_result[i] = ext_result[i];
        // pin override ignores enable; drives only with direction cleared
        assign cmp_pin_oe[i]  = ctrl0_q[i][`CMP_BIT_ROUTE] & ~pin_direction_bit[i];
        assign cmp_pin_out[i] = ext_result[i];

        assign analog_enable[i]     = ctrl0_q[i][`CMP_BIT_ENABLE];
        assign analog_speed_fast[i] = ctrl0_q[i][`CMP_BIT_SPEED];
        assign analog_hyst_en[i]    = ctrl0_q[i][`CMP_BIT_HYST];
        // all inputs disconnect while the comparator is off
        assign analog_inputs_on[i]  = ctrl0_q[i][`CMP_BIT_ENABLE];
        // code 11 means shared pin on one, ground on two; the analog side
        // knows which instance it is
        assign cmp_pos_sel[i] = pos_sel_type'(ctrl1_q[i][`CMP_POS_HI:`CMP_POS_LO]);
        assign cmp_neg_sel[i] = neg_sel_type'(ctrl1_q[i][`CMP_NEG_HI:`CMP_NEG_LO]);
    end

    //--------------------------------------------------------------
    // write channel
    //--------------------------------------------------------------
    // a new address or data word waits for bready, so one answer is outstanding
    assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
    assign wr_fire       = aw_full_q & w_full_q & ~s_axi_bvalid;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            w_full_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    always_comb begin
        unique case (aw_addr_q)
            `CMP_OFS_CTRL0_C1, `CMP_OFS_CTRL1_C1, `CMP_OFS_CTRL0_C2,
            `CMP_OFS_CTRL1_C2, `CMP_OFS_MIRROR, `CMP_OFS_FLAGS,
            `CMP_OFS_PINCFG, `CMP_OFS_PORTRD: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // register write decode
    //--------------------------------------------------------------
    logic       wr_lane0;
    logic [1:0] wr_ctrl0;
    logic [1:0] wr_ctrl1;
    logic       wr_flags;
    logic       wr_pincfg;

    // only byte lane 0 holds register bits, so the other strobes are ignored
    assign wr_lane0    = wr_fire & w_strb_q[0];
    assign wr_ctrl0[0] = wr_lane0 & (aw_addr_q == `CMP_OFS_CTRL0_C1);
    assign wr_ctrl0[1] = wr_lane0 & (aw_addr_q == `CMP_OFS_CTRL0_C2);
    assign wr_ctrl1[0] = wr_lane0 & (aw_addr_q == `CMP_OFS_CTRL1_C1);
    assign wr_ctrl1[1] = wr_lane0 & (aw_addr_q == `CMP_OFS_CTRL1_C2);
    assign wr_flags    = wr_lane0 & (aw_addr_q == `CMP_OFS_FLAGS);
    assign wr_pincfg   = wr_lane0 & (aw_addr_q == `CMP_OFS_PINCFG);

    //--------------------------------------------------------------
    // control registers, one set per comparator
    //--------------------------------------------------------------
    // writes to read-only and unimplemented bits are dropped by the masks
    for (genvar i = 0; i < 2; i++) begin : g_regs
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                ctrl0_q[i] <= `CMP_CTRL0_RST;
            end else if (wr_ctrl0[i]) begin
                ctrl0_q[i] <= w_data_q[7:0] & `CMP_CTRL0_WMASK;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                ctrl1_q[i] <= `CMP_CTRL1_RST;
            end else if (wr_ctrl1[i]) begin
                ctrl1_q[i] <= w_data_q[7:0] & `CMP_CTRL1_WMASK;
            end
        end
    end

    // mirror and port-read offsets accept writes and change nothing
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            analog_cfg_q <= `CMP_PINCFG_RST;
        end else if (wr_pincfg) begin
            analog_cfg_q <= w_data_q[7:0];
        end
    end

    //--------------------------------------------------------------
    // interrupt flags
    //--------------------------------------------------------------
    // write one to clear; an edge in the same cycle wins
    for (genvar i = 0; i < 2; i++) begin : g_flag
        logic flag_clr;

        assign flag_clr = wr_flags & w_data_q[i];

        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                flag_q[i] <= 1'b0;
            end else if (edge_pulse[i]) begin
                flag_q[i] <= 1'b1;
            end else if (flag_clr) begin
                flag_q[i] <= 1'b0;
            end
        end
    end
    assign cmp_irq_flag = flag_q;

    //--------------------------------------------------------------
    // read channel
    //--------------------------------------------------------------
    logic [7:0] rd_byte;
    logic       rd_ok;
    logic [7:0] ctrl0_view [2];

    // the live result is merged into bit 6, which has no storage of its own
    for (genvar i = 0; i < 2; i++) begin : g_view
        assign ctrl0_view[i] = ctrl0_q[i] | {1'b0, result_q[i], 6'h00};
    end

    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        unique case (s_axi_araddr)
            `CMP_OFS_CTRL0_C1: rd_byte = ctrl0_view[0];
            `CMP_OFS_CTRL0_C2: rd_byte = ctrl0_view[1];
            `CMP_OFS_CTRL1_C1: rd_byte = ctrl1_q[0];
            `CMP_OFS_CTRL1_C2: rd_byte = ctrl1_q[1];
            `CMP_OFS_MIRROR:   rd_byte = {6'h00, result_q[1], result_q[0]};
            `CMP_OFS_FLAGS:    rd_byte = {6'h00, flag_q};
            `CMP_OFS_PINCFG:   rd_byte = analog_cfg_q;
            `CMP_OFS_PORTRD:   rd_byte = port_pins_in & ~analog_cfg_q;
            default:           rd_ok   = 1'b0;
        endcase
    end

    // araddr is decoded at the accepting edge; rdata then holds until rready
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : cmp_ctrl

// File: bench/cmp_ctrl_assertions.sv
// Purpose: port-level checks of the comparator control block
// Assumes: one clock domain, sys_rst synchronous active high
// Notes:   bound to cmp_ctrl after the module
`timescale 1ns/1ps
module cmp_ctrl_assertions (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  pin_direction_bit,
    input wire logic [1:0]  cmp_pin_out,
    input wire logic [1:0]  cmp_pin_oe,
    input wire logic [1:0]  timer_gate_result,
    input wire logic [1:0]  cmp_irq_flag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_wr_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_unmapped: assert property (rd_taken and s_axi_araddr > 8'h1C |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answer pending");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer withdrawn early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer withdrawn early");
    chk_pin_drive: assert property ((cmp_pin_oe & pin_direction_bit) == 2'h0)
        else $error("pin driven while set as input");
    chk_pin_timer: assert property (cmp_pin_out == timer_gate_result)
        else $error("pin and timer results differ");
    // a flag may only drop through a software clear, seen as a write answer
    chk_flag_clear: assert property ($fell(cmp_irq_flag[0]) || $fell(cmp_irq_flag[1]) |->
        s_axi_bvalid || $past(s_axi_bvalid)) else $error("flag dropped without clear");
endmodule : cmp_ctrl_assertions

bind cmp_ctrl cmp_ctrl_assertions i_chk (.ref_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .pin_direction_bit, .cmp_pin_out, .cmp_pin_oe,
    .timer_gate_result, .cmp_irq_flag);

// File: bench/dual_comparator_control_tb_top.sv
// Purpose: self-checking bench of the dual comparator control block
// Assumes: AXI4-Lite master tasks, 250 MHz clock
// Notes:   timer clock is stepped on ref_clk edges since it is synchronous
`timescale 1ns/1ps
module dual_comparator_control_tb_top;
    import cmp_ctrl_pkg::*;
    logic        ref_clk, sys_rst = 1'b1, timer_clk_in = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, port_pins_in = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  raw_result = 2'h0, pin_direction_bit = 2'h0, last_resp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, cmp_pin_out, cmp_pin_oe, timer_gate_result;
    logic [1:0]  cmp_irq_flag, analog_enable, analog_speed_fast, analog_hyst_en;
    logic [1:0]  analog_inputs_on;
    pos_sel_type cmp_pos_sel [2];
    neg_sel_type cmp_neg_sel [2];
    int          bad_count = 0, n_checks = 0, cycles = 0;

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    cmp_ctrl i_dut (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .raw_result, .timer_clk_in,
        .pin_direction_bit, .port_pins_in, .cmp_pin_out, .cmp_pin_oe, .timer_gate_result,
        .cmp_irq_flag, .analog_enable, .analog_speed_fast, .analog_hyst_en,
        .analog_inputs_on, .cmp_pos_sel, .cmp_neg_sel);

    // ------------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // let the result path follow the new settings before ports are checked
        cyc(2);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
    endtask : rd

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        cyc(10);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd(8'(i * 4), (i < 4 && i % 2 == 0) ? 32'h4 : 32'h0);
        chk(analog_speed_fast, 2'h3);
        rd(8'h20, 32'h0);
        chk(last_resp, 2'h2);
        wr(8'h00, 8'hFF);
        chk(last_resp, 2'h0);
        chk(analog_inputs_on, 2'h1);
        rd(8'h00, 32'hF7);
        chk({analog_enable[0], analog_hyst_en[0], analog_speed_fast[0]}, 3'h7);
        wr(8'h00, 8'h00);
        chk({analog_enable[0], analog_hyst_en[0], analog_speed_fast[0]}, 3'h0);
        $display("test reset_fields done");
        for (int j = 0; j < 4; j++) begin
            wr(8'h04, {2'h3, 2'(j), 2'h3, 2'(j)});
            wr(8'h0C, {2'h0, 2'(3 - j), 2'h0, 2'(j)});
            rd(8'h04, {24'h0, 2'h3, 2'(j), 2'h0, 2'(j)});
            chk({cmp_pos_sel[0], cmp_neg_sel[0], cmp_pos_sel[1], cmp_neg_sel[1]},
                {2'(j), 2'(j), 2'(3 - j), 2'(j)});
        end
        wr(8'h04, 8'h00);
        wr(8'h0C, 8'h00);
        $display("test selects done");
        wr(8'h00, 8'h80);
        wr(8'h08, 8'h80);
        raw_result <= 2'h1;
        cyc(6);
        rd(8'h00, 32'hC0);
        rd(8'h10, 32'h1);
        raw_result <= 2'h3;
        cyc(6);
        rd(8'h10, 32'h3);
        wr(8'h08, 8'h90);
        rd(8'h08, 32'h90);
        rd(8'h10, 32'h1);
        wr(8'h00, 8'h20);
        chk(cmp_pin_oe, 2'h1);
        pin_direction_bit <= 2'h1;
        cyc(2);
        chk(cmp_pin_oe, 2'h0);
        pin_direction_bit <= 2'h0;
        wr(8'h00, 8'hA0);
        chk({cmp_pin_oe[0], cmp_pin_out[0], timer_gate_result[0]}, 3'h7);
        $display("test result_route done");
        raw_result <= 2'h0;
        wr(8'h04, 8'h80);
        cyc(6);
        wr(8'h14, 8'h03);
        chk(cmp_irq_flag, 2'h0);
        raw_result <= 2'h1;
        cyc(6);
        rd(8'h14, 32'h1);
        wr(8'h14, 8'h01);
        chk(cmp_irq_flag[0], 1'b0);
        raw_result <= 2'h0;
        cyc(6);
        chk(cmp_irq_flag[0], 1'b0);
        wr(8'h04, 8'h40);
        raw_result <= 2'h1;
        cyc(6);
        chk(cmp_irq_flag[0], 1'b0);
        raw_result <= 2'h0;
        cyc(6);
        chk(cmp_irq_flag[0], 1'b1);
        // the rising edge reaches the flag at the very edge of the clearing write
        wr(8'h04, 8'h80);
        wr(8'h14, 8'h01);
        raw_result <= 2'h1;
        cyc(1);
        wr(8'h14, 8'h01);
        chk(cmp_irq_flag[0], 1'b1);
        raw_result <= 2'h0;
        cyc(6);
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h80);
        wr(8'h14, 8'h03);
        wr(8'h00, 8'h10);
        cyc(4);
        chk(cmp_irq_flag[0], 1'b1);
        $display("test flags done");
        wr(8'h00, 8'hA1);
        timer_clk_in <= 1'b1;
        cyc(2);
        timer_clk_in <= 1'b0;
        cyc(4);
        timer_clk_in <= 1'b1;
        raw_result <= 2'h1;
        cyc(8);
        chk(cmp_pin_out[0], 1'b0);
        timer_clk_in <= 1'b0;
        cyc(4);
        chk(cmp_pin_out[0], 1'b1);
        wr(8'h18, 8'h0F);
        port_pins_in <= 8'hFF;
        rd(8'h1C, 32'hF0);
        wr(8'h20, 8'h55);
        chk(last_resp, 2'h2);
        $display("test sync_port done");
        results();
    end
endmodule : dual_comparator_control_tb_top
